// ### verilog/osgw_top.sv
`timescale 1ns/100ps
// Contract
// - indices 1-7,9-14 get table gain plus offset
// - 0 mutes, 8 gain only, 15 frame marker
// - offset code n builds 7-bit value
// - 32 eight-bit group gains over subcarrier groups
// - data access uses pointer, then pointer increments
// - control write loads pointer directly
// - pointer k packs gains 4k..4k+3 low first
// - default taper is fixed logic, no half term
// - 128x30 window table reachable over SPI
// - group i spans start+i*size; 8k doubles size
// - start field 13 bits, size field 8 bits
// - 6-bit input extended by half LSB
module osgw_top
  import osgw_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        mode_8k,
  input  wire osgw_sym_t   sym_in,
  input  wire logic        sym_valid,
  output logic             sym_ready,
  input  wire logic [6:0]  win_pos,
  output logic [29:0]      win_coef,
  output osgw_out_t        sym_out,
  output logic             sym_out_valid,
  input  wire logic        sym_out_ready
);
  osgw_eqctl_t  eq_ctl;
  logic [7:0]   eq_gain [OSGW_EQ_GROUPS];
  logic [7:0]   bal_gain [OSGW_BAL_ENTRIES];
  logic [2:0]   bal_ofs [OSGW_BAL_ENTRIES];
  logic [OSGW_WIN_W-1:0] win_tab [OSGW_WIN_ENTRIES];
  logic         win_use_table;
  logic         data_acc;
  logic [3:0]   bal_sel;
  logic         fifo_in_ready;
  osgw_out_t    stage;
  logic         stage_valid;
  logic         fifo_out_valid;
  logic [$bits(osgw_out_t)-1:0] fifo_out_data;

  assign data_acc = (reg_wr || reg_rd) && reg_addr == OSGW_ADDR_EQ_DATA;
  assign bal_sel  = 4'(reg_addr - OSGW_ADDR_BAL_BASE);

  // control register, pointer auto-advance on every data access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eq_ctl <= '0;
    end else if (reg_wr && reg_addr == OSGW_ADDR_EQ_CTRL) begin
      eq_ctl.ptr   <= reg_wdata[OSGW_PTR_LSB +: 3];
      eq_ctl.size  <= reg_wdata[OSGW_SIZE_LSB +: 8];
      eq_ctl.start <= reg_wdata[OSGW_START_LSB +: 13];
    end else if (data_acc) begin
      eq_ctl.ptr <= eq_ctl.ptr + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int g = 0; g < OSGW_EQ_GROUPS; g++) eq_gain[g] <= OSGW_GAIN_UNITY;
    end else if (reg_wr && reg_addr == OSGW_ADDR_EQ_DATA) begin
      for (int b = 0; b < 4; b++) begin
        eq_gain[{eq_ctl.ptr, 2'(b)}] <= reg_wdata[8*b +: 8];
      end
    end
  end

  // bit-loading table: gain in 7:0, offset code in 10:8
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int e = 0; e < OSGW_BAL_ENTRIES; e++) begin
        bal_gain[e] <= OSGW_GAIN_UNITY;
        bal_ofs[e]  <= OSGW_OFS_NONE;
      end
    end else if (reg_wr && reg_addr >= OSGW_ADDR_BAL_BASE
                 && reg_addr < OSGW_ADDR_BAL_BASE + 12'(OSGW_BAL_ENTRIES)) begin
      bal_gain[bal_sel] <= reg_wdata[7:0];
      bal_ofs[bal_sel]  <= reg_wdata[10:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_use_table <= 1'b0;
    end else if (reg_wr && reg_addr == OSGW_ADDR_WIN_CFG) begin
      win_use_table <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr >= OSGW_ADDR_WIN_BASE
        && reg_addr < OSGW_ADDR_WIN_BASE + 12'(OSGW_WIN_ENTRIES)) begin
      win_tab[7'(reg_addr - OSGW_ADDR_WIN_BASE)] <= reg_wdata[OSGW_WIN_W-1:0];
    end
  end

  // read path, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == OSGW_ADDR_EQ_CTRL) begin
          reg_rdata <= {7'h00, eq_ctl.start, eq_ctl.size, 1'b0, eq_ctl.ptr};
        end else if (reg_addr == OSGW_ADDR_EQ_DATA) begin
          reg_rdata <= {eq_gain[{eq_ctl.ptr, 2'h3}], eq_gain[{eq_ctl.ptr, 2'h2}],
                        eq_gain[{eq_ctl.ptr, 2'h1}], eq_gain[{eq_ctl.ptr, 2'h0}]};
        end else if (reg_addr == OSGW_ADDR_WIN_CFG) begin
          reg_rdata <= {31'h0, win_use_table};
        end else if (reg_addr >= OSGW_ADDR_WIN_BASE
                     && reg_addr < OSGW_ADDR_WIN_BASE + 12'(OSGW_WIN_ENTRIES)) begin
          reg_rdata <= {2'h0, win_tab[7'(reg_addr - OSGW_ADDR_WIN_BASE)]};
        end else if (reg_addr >= OSGW_ADDR_BAL_BASE
                     && reg_addr < OSGW_ADDR_BAL_BASE + 12'(OSGW_BAL_ENTRIES)) begin
          reg_rdata <= {21'h0, bal_ofs[bal_sel], bal_gain[bal_sel]};
        end else begin
          reg_rdata <= '0;
        end
      end
    end
  end

  // fixed taper: quarter-sine ramp without the half-sample shift
  function automatic logic [29:0] osgw_taper(input logic [6:0] p);
    logic [13:0] x;
    logic [27:0] sq;
    x  = {p, 7'h00};
    sq = x * x;
    // ramp 2x^2 minus x^3/2^27 (sq summed twice, cube shifted down 27), cheap in logic
    osgw_taper = {2'h0, sq[27:0]} + {2'h0, sq[27:0]} - 30'(({16'h0, sq[27:14]} * {16'h0, x}) >> 13);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_coef <= '0;
    end else if (win_use_table) begin
      win_coef <= win_tab[win_pos];
    end else begin
      win_coef <= osgw_taper(win_pos);
    end
  end

  // subcarrier datapath
  logic [7:0]  map_gain;
  logic [2:0]  map_ofs;
  logic [6:0]  ext_i;
  logic [6:0]  ext_q;
  logic [12:0] grp_size;
  logic [12:0] rel;
  logic [12:0] grp_idx;
  logic [7:0]  grp_gain;
  logic        in_band;
  logic [15:0] prod_i;
  logic [15:0] prod_q;
  logic [6:0]  half_l;

  assign map_gain = bal_gain[sym_in.idx - 4'h1];
  assign map_ofs  = bal_ofs[sym_in.idx - 4'h1];
  assign half_l   = 7'h01 << (map_ofs - 3'h1);

  always_comb begin
    ext_i = {sym_in.i, 1'b0};
    ext_q = {sym_in.q, 1'b0};
    if (sym_in.idx != OSGW_IDX_PILOT) begin
      if (map_ofs == OSGW_OFS_PLUS1) begin
        ext_i = {sym_in.i, 1'b1};
      end else if (map_ofs != OSGW_OFS_NONE) begin
        ext_i = {sym_in.i, 1'b0} + half_l;
        ext_q = {sym_in.q, 1'b0} + half_l;
      end
    end
  end

  assign grp_size = mode_8k ? {4'h0, eq_ctl.size, 1'b0} : {5'h00, eq_ctl.size};
  assign rel      = sym_in.sc - eq_ctl.start;
  assign grp_idx  = (grp_size == '0) ? 13'h0 : rel / grp_size;
  assign in_band  = sym_in.sc >= eq_ctl.start && grp_idx < 13'(OSGW_EQ_GROUPS);
  assign grp_gain = in_band ? eq_gain[grp_idx[4:0]] : OSGW_GAIN_UNITY;

  always_comb begin
    logic signed [15:0] ti;
    logic signed [15:0] tq;
    ti = 16'(signed'(ext_i)) * signed'({8'h00, map_gain});
    tq = 16'(signed'(ext_q)) * signed'({8'h00, map_gain});
    prod_i = 16'((32'(signed'(ti)) * signed'({24'h0, grp_gain})) >>> 7);
    prod_q = 16'((32'(signed'(tq)) * signed'({24'h0, grp_gain})) >>> 7);
    if (sym_in.idx == OSGW_IDX_MUTE || sym_in.idx == OSGW_IDX_FRAME) begin
      prod_i = '0;
      prod_q = '0;
    end
  end

  // ready is registered from a count of beats in stage plus fifo;
  // the stage is a spare slot, so a beat taken at count 15 still fits
  logic [4:0]  held;
  logic [4:0]  next_held;
  logic        take;
  logic        fifo_pop;

  assign take      = sym_valid && sym_ready;
  assign fifo_pop  = fifo_out_valid && (!sym_out_valid || sym_out_ready);
  assign next_held = held + 5'(take) - 5'(fifo_pop);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      held      <= '0;
      sym_ready <= 1'b0;
    end else begin
      held      <= next_held;
      sym_ready <= next_held < 5'(OSGW_FIFO_DEPTH);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage       <= '0;
      stage_valid <= 1'b0;
    end else if (!stage_valid || fifo_in_ready) begin
      stage_valid <= take;
      if (take) begin
        stage.i     <= prod_i;
        stage.q     <= prod_q;
        stage.frame <= sym_in.idx == OSGW_IDX_FRAME;
        stage.last  <= sym_in.last;
      end
    end
  end

  osgw_fifo #(.W($bits(osgw_out_t)), .D(OSGW_FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   (stage),
    .in_valid  (stage_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (!sym_out_valid || sym_out_ready)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sym_out       <= '0;
      sym_out_valid <= 1'b0;
    end else if (!sym_out_valid || sym_out_ready) begin
      sym_out_valid <= fifo_out_valid;
      sym_out       <= fifo_out_data;
    end
  end

  AST_PTR_ADV: assert property (@(posedge clk_sys) disable iff (!rst_n)
    data_acc && !(reg_wr && reg_addr == OSGW_ADDR_EQ_CTRL) |=> eq_ctl.ptr == $past(eq_ctl.ptr) + 3'h1)
    else $error("pointer did not advance");
  AST_PTR_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == OSGW_ADDR_EQ_CTRL |=> eq_ctl.ptr == $past(reg_wdata[2:0]))
    else $error("pointer not loaded");
  AST_CTL_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == OSGW_ADDR_EQ_CTRL |=> reg_rdata[3] == 1'b0 && reg_rdata[31:25] == 7'h00)
    else $error("control reserved bits nonzero");
  AST_MUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_ready && sym_valid && sym_in.idx == OSGW_IDX_MUTE |=> stage.i == 16'h0 && stage.q == 16'h0)
    else $error("mute index not zeroed");
  AST_FRAME: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_ready && sym_valid |=> stage.frame == ($past(sym_in.idx) == OSGW_IDX_FRAME))
    else $error("frame flag wrong");
  AST_WIN_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    win_use_table && $stable(win_use_table) |=> win_coef == win_tab[$past(win_pos)])
    else $error("table taper not selected");
  AST_GRP_DBL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_8k |-> grp_size == {4'h0, eq_ctl.size, 1'b0})
    else $error("8k group size not doubled");
  AST_DATA_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == OSGW_ADDR_EQ_DATA |=> reg_rdata[7:0] == eq_gain[{$past(eq_ctl.ptr), 2'h0}])
    else $error("data read lane wrong");

  sequence osgw_beat_take;
    sym_valid && sym_ready;
  endsequence
  sequence osgw_pilot_take;
    sym_valid && sym_ready && sym_in.idx == OSGW_IDX_PILOT;
  endsequence
  sequence osgw_dat_write;
    reg_wr && reg_addr == OSGW_ADDR_EQ_DATA;
  endsequence

  AST_TAKE_STAGED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osgw_beat_take |=> stage_valid)
    else $error("accepted beat not staged");
  AST_PILOT_GAIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osgw_pilot_take |-> ext_i == {sym_in.i, 1'b0} && ext_q == {sym_in.q, 1'b0})
    else $error("pilot received an offset");
  AST_LANE_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osgw_dat_write |=> eq_gain[{$past(eq_ctl.ptr), 2'h3}] == $past(reg_wdata[31:24]))
    else $error("data write top lane wrong");
  AST_OUT_STANDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sym_out_valid && !sym_out_ready |=> sym_out_valid && $stable(sym_out))
    else $error("output changed before it was taken");
endmodule

// ### verilog/osgw_pkg.sv
package osgw_pkg;
  // register addresses (SPI word addresses, printed offsets)
  localparam logic [11:0] OSGW_ADDR_EQ_CTRL   = 12'h742;
  localparam logic [11:0] OSGW_ADDR_EQ_DATA   = 12'h743;
  localparam logic [11:0] OSGW_ADDR_WIN_CFG   = 12'h7A0;
  localparam logic [11:0] OSGW_ADDR_WIN_BASE  = 12'h800;
  localparam logic [11:0] OSGW_ADDR_BAL_BASE  = 12'h744;
  localparam int          OSGW_BAL_ENTRIES    = 14;
  localparam int          OSGW_WIN_ENTRIES    = 128;
  localparam int          OSGW_WIN_W          = 30;
  localparam int          OSGW_EQ_GROUPS      = 32;
  localparam int          OSGW_FIFO_DEPTH     = 16;
  // control register fields
  localparam int          OSGW_PTR_LSB        = 0;
  localparam int          OSGW_SIZE_LSB       = 4;
  localparam int          OSGW_START_LSB      = 12;
  // bit-loading index codes
  localparam logic [3:0]  OSGW_IDX_MUTE       = 4'h0;
  localparam logic [3:0]  OSGW_IDX_PILOT      = 4'h8;
  localparam logic [3:0]  OSGW_IDX_FRAME      = 4'hF;
  localparam logic [2:0]  OSGW_OFS_PLUS1      = 3'h0;
  localparam logic [2:0]  OSGW_OFS_NONE       = 3'h7;
  localparam logic [7:0]  OSGW_GAIN_UNITY     = 8'h80;
  localparam logic [12:0] OSGW_8K_SPAN        = 13'h1FFF;

  typedef struct packed {
    logic [5:0] i;
    logic [5:0] q;
    logic [3:0] idx;
    logic [12:0] sc;
    logic       last;
  } osgw_sym_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic        frame;
    logic        last;
  } osgw_out_t;

  typedef struct packed {
    logic [12:0] start;
    logic [7:0]  size;
    logic [2:0]  ptr;
  } osgw_eqctl_t;
endpackage

// ### verilog/osgw_fifo.sv
`timescale 1ns/100ps
module osgw_fifo #(
  parameter int W = 30,
  parameter int D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(D);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule

// ### test/osgw_host.sv
`timescale 1ns/100ps
module osgw_host
  import osgw_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [11:0]      reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
  end
  // released bus shows the inverse, so a stale address never passes for a hold
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // control first with pointer 0, then eight words of four gains each
  task automatic load_eq(input logic [12:0] start, input logic [7:0] size, input logic [7:0] base);
    int k;
    wr(OSGW_ADDR_EQ_CTRL, {7'h00, start, size, 1'b0, 3'h0});
    for (k = 0; k < 8; k++) begin
      wr(OSGW_ADDR_EQ_DATA, {base + 8'(4 * k + 3), base + 8'(4 * k + 2), base + 8'(4 * k + 1), base + 8'(4 * k)});
    end
  endtask
  task automatic set_bal(input logic [3:0] idx, input logic [7:0] gain, input logic [2:0] n);
    wr(OSGW_ADDR_BAL_BASE + 12'(idx) - 12'h001, {21'h0, n, gain});
  endtask
endmodule

// ### test/osgw_top_tb_top.sv
`timescale 1ns/100ps
module osgw_top_tb_top
  import osgw_pkg::*;
;
  logic        clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, mode_8k, sym_valid, sym_ready;
  logic        sym_out_valid, sym_out_ready;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [6:0]  win_pos;
  logic [29:0] win_coef;
  osgw_sym_t   sym_in;
  osgw_out_t   sym_out;
  osgw_out_t   got[$];
  logic [7:0]  tgv[16];
  logic [2:0]  nv[16];
  int          failures, tests_run;
  osgw_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mode_8k(mode_8k), .sym_in(sym_in),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .win_pos(win_pos), .win_coef(win_coef), .sym_out(sym_out),
    .sym_out_valid(sym_out_valid), .sym_out_ready(sym_out_ready));
  osgw_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (sym_out_valid === 1'b1 && sym_out_ready === 1'b1) got.push_back(sym_out);
  task automatic end_of_test();
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] calc(logic [5:0] x, logic [3:0] idx, logic [7:0] gg, bit q);
    int e;
    e = 2 * int'($signed(x));
    if (idx != OSGW_IDX_PILOT && nv[idx] != OSGW_OFS_NONE) e += (nv[idx] == 3'h0) ? int'(!q) : (1 << (nv[idx] - 1));
    e = (e * int'(tgv[idx]) * int'(gg)) >>> 7;
    return (idx == OSGW_IDX_MUTE || idx == OSGW_IDX_FRAME) ? 16'h0000 : e[15:0];
  endfunction
  function automatic logic [7:0] ggain(int sc);
    int sz;
    sz = mode_8k ? 240 : 120;
    return (sc < 128 || sc >= 128 + 32 * sz) ? OSGW_GAIN_UNITY : 8'h40 + 8'((sc - 128) / sz);
  endfunction
  task automatic send(input logic [3:0] idx, input logic [12:0] sc, input logic last);
    @(negedge clk_sys);
    sym_in = '{i: 6'h05, q: 6'h09, idx: idx, sc: sc, last: last};
    sym_valid = 1'b1;
    @(posedge clk_sys);
    while (sym_ready !== 1'b1) @(posedge clk_sys);
  endtask
  task automatic expect_out(input logic [3:0] idx, input logic [12:0] sc, input logic last);
    osgw_out_t e, s;
    int n;
    e = '{i: calc(6'h05, idx, ggain(sc), 0), q: calc(6'h09, idx, ggain(sc), 1), frame: idx == OSGW_IDX_FRAME, last: last};
    for (n = 0; n < 60 && got.size() == 0; n++) @(negedge clk_sys);
    s = (got.size() == 0) ? ~e : got.pop_front();
    check(64'(s), 64'(e));
  endtask
  task automatic beat(input logic [3:0] idx, input logic [12:0] sc, input logic last);
    send(idx, sc, last);
    @(negedge clk_sys);
    sym_valid = 1'b0;
    expect_out(idx, sc, last);
  endtask
  task automatic t_reset();
    int k;
    host.rd(OSGW_ADDR_EQ_CTRL, rv);
    check(64'(rv), 64'h0);
    for (k = 0; k < 9; k++) begin
      host.rd(OSGW_ADDR_EQ_DATA, rv);
      check(64'(rv), 64'h80808080);
    end
    host.rd(12'h123, rv);
    check(64'(rv), 64'h0);
  endtask
  task automatic t_eq_regs();
    host.wr(OSGW_ADDR_EQ_CTRL, 32'hFFFFFFFF);
    host.rd(OSGW_ADDR_EQ_CTRL, rv);
    check(64'(rv), 64'h01FFFFF7);
    host.load_eq(13'h0080, 8'h78, 8'h40);
    host.rd(OSGW_ADDR_EQ_CTRL, rv);
    check(64'(rv), 64'h00080780);
    host.wr(OSGW_ADDR_EQ_CTRL, 32'h00080785);
    host.rd(OSGW_ADDR_EQ_DATA, rv);
    check(64'(rv), 64'h57565554);
    host.rd(OSGW_ADDR_EQ_DATA, rv);
    check(64'(rv), 64'h5B5A5958);
  endtask
  task automatic t_codes();
    int k;
    for (k = 1; k < 15; k++) begin
      tgv[k] = (k == 8) ? 8'h81 : 8'h50 + 8'(k);
      nv[k] = 3'(k - 1 - int'(k > 8));
      host.set_bal(4'(k), tgv[k], (k == 8) ? 3'h3 : nv[k]);
    end
    for (k = 0; k < 16; k++) beat(4'(k), 13'd370, k == 15);
  endtask
  task automatic t_groups();
    int k;
    int scs[8] = '{127, 128, 247, 248, 3967, 3968, 367, 368};
    for (k = 0; k < 8; k++) begin
      mode_8k = (k > 5);
      beat(4'h1, 13'(scs[k]), 1'b0);
    end
    mode_8k = 1'b0;
  endtask
  task automatic t_fifo();
    int k, m;
    sym_out_ready = 1'b0;
    k = 0;
    while (k < 40 && sym_ready === 1'b1) begin
      send(4'h3, 13'd200, k[0]);
      k++;
      @(negedge clk_sys);
      sym_valid = 1'b0;
    end
    check(64'(sym_ready), 64'h0);
    for (m = 0; m < k; m++) begin
      sym_out_ready = 1'b0;
      @(negedge clk_sys);
      check(64'(sym_out_valid), 64'h1);
      sym_out_ready = 1'b1;
      expect_out(4'h3, 13'd200, m[0]);
    end
    sym_out_ready = 1'b1;
  endtask
  task automatic t_window();
    win_pos = 7'h7F;
    repeat (3) @(negedge clk_sys);
    check(64'(win_coef != 30'h0), 64'h1);
    host.wr(OSGW_ADDR_WIN_BASE + 12'h07F, 32'h2ABCDE12);
    host.wr(OSGW_ADDR_WIN_CFG, 32'h00000001);
    host.rd(OSGW_ADDR_WIN_BASE + 12'h07F, rv);
    check(64'(rv), 64'h2ABCDE12);
    repeat (3) @(negedge clk_sys);
    check(64'(win_coef), 64'h2ABCDE12);
  endtask
  initial begin
    failures = 0;
    tests_run = 0;
    rst_n = 1'b0;
    mode_8k = 1'b0;
    sym_in = '0;
    sym_valid = 1'b0;
    sym_out_ready = 1'b1;
    win_pos = 7'h00;
    foreach (tgv[k]) tgv[k] = OSGW_GAIN_UNITY;
    foreach (nv[k]) nv[k] = OSGW_OFS_NONE;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_eq_regs();
    t_codes();
    t_groups();
    t_fifo();
    t_window();
    end_of_test();
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
